// File: rtl/srr_status_regs.sv
`timescale 1ns/1ns
module srr_status_regs (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [2:0] reg_sel,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic srq,
  input wire logic trig_enabled,
  input wire logic trig_ext_src,
  input wire logic trig_in,
  input wire logic transient_armed,
  input wire logic cv_mode,
  input wire logic cc_mode,
  input wire logic transient_done,
  input wire logic sample_done,
  input wire logic list_done,
  input wire logic list_running,
  input wire logic current_mode,
  input wire logic voltage_mode,
  input wire logic thermal_err,
  input wire logic slave_fault,
  input wire logic volt_prot_err,
  input wire logic curr_prot_err,
  input wire logic ext_ref_en,
  input wire logic sinking,
  input wire logic std_event_summary,
  input wire logic err_queue_nonempty,
  input wire logic msg_avail
);

  function automatic logic [15:0] srr_next_event(input logic [15:0] ev, input logic [15:0] old_c,
      input logic [15:0] new_c, input logic clr);
    logic [15:0] held;
    held = clr ? 16'h0000 : ev;
    srr_next_event = held | (new_c & ~old_c);
  endfunction

  logic trig_meta;
  logic trig_sync;
  logic trigger_wait_flag;
  logic next_trigger_wait_flag;
  logic [15:0] op_cond;
  logic [15:0] next_op_cond;
  logic [15:0] op_event;
  logic [15:0] op_enable;
  logic [15:0] ques_cond;
  logic [15:0] next_ques_cond;
  logic [15:0] ques_event;
  logic [15:0] questionable_enable_mask;
  logic [7:0] sr_enable;
  logic [7:0] status_byte;
  logic prot_any;
  logic op_rd_clr;
  logic q_rd_clr;
  logic rqs;

  // trigger input pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      trig_meta <= 1'h0;
      trig_sync <= 1'h0;
    end else if (clk_en) begin
      trig_meta <= trig_in;
      trig_sync <= trig_meta;
    end
  end

  always_comb begin
    next_trigger_wait_flag = trig_enabled
      | (trigger_wait_flag & trig_ext_src & ~trig_sync);
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      trigger_wait_flag <= 1'h0;
    end else if (clk_en) begin
      trigger_wait_flag <= next_trigger_wait_flag;
    end
  end

  always_comb begin
    next_op_cond = 16'h0000;
    next_op_cond[srr_pkg::OP_WAIT_TRIG] = next_trigger_wait_flag;
    next_op_cond[srr_pkg::OP_ARMED] = transient_armed;
    next_op_cond[srr_pkg::OP_CV] = cv_mode;
    next_op_cond[srr_pkg::OP_CC] = cc_mode;
    next_op_cond[srr_pkg::OP_TRANS_DONE] = transient_done;
    next_op_cond[srr_pkg::OP_SAMPLE_DONE] = sample_done;
    next_op_cond[srr_pkg::OP_LIST_DONE] = list_done;
    next_op_cond[srr_pkg::OP_LIST_RUN] = list_running;
  end

  always_comb begin
    prot_any = volt_prot_err | curr_prot_err;
    next_ques_cond = 16'h0000;
    next_ques_cond[srr_pkg::Q_CURR_MODE] = current_mode;
    next_ques_cond[srr_pkg::Q_VOLT_MODE] = voltage_mode;
    next_ques_cond[srr_pkg::Q_THERMAL] = thermal_err;
    next_ques_cond[srr_pkg::Q_SLAVE] = slave_fault;
    next_ques_cond[srr_pkg::Q_VPROT] = volt_prot_err | (ext_ref_en & prot_any);
    next_ques_cond[srr_pkg::Q_CPROT] = curr_prot_err | (ext_ref_en & prot_any);
    next_ques_cond[srr_pkg::Q_SINK] = sinking;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      op_cond <= srr_pkg::GROUP_RESET;
      ques_cond <= srr_pkg::GROUP_RESET;
    end else if (clk_en) begin
      op_cond <= next_op_cond;
      ques_cond <= next_ques_cond;
    end
  end

  assign op_rd_clr = rd_stb && reg_sel == srr_pkg::SEL_OP_EVENT;
  assign q_rd_clr = rd_stb && reg_sel == srr_pkg::SEL_QUES_EVENT;

  // event registers: new edges win over a clearing read
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      op_event <= srr_pkg::GROUP_RESET;
      ques_event <= srr_pkg::GROUP_RESET;
    end else if (clk_en) begin
      op_event <= srr_next_event(op_event, op_cond, next_op_cond, op_rd_clr);
      ques_event <= srr_next_event(ques_event, ques_cond, next_ques_cond, q_rd_clr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      op_enable <= srr_pkg::GROUP_RESET;
      questionable_enable_mask <= srr_pkg::GROUP_RESET;
      sr_enable <= srr_pkg::BYTE_RESET;
    end else if (clk_en && wr_stb) begin
      case (reg_sel)
        srr_pkg::SEL_OP_ENABLE: begin
          op_enable <= wr_data;
        end
        srr_pkg::SEL_QUES_ENABLE: begin
          questionable_enable_mask <= wr_data;
        end
        srr_pkg::SEL_SR_ENABLE: begin
          sr_enable <= wr_data[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[srr_pkg::SB_QUES] = |(ques_event & questionable_enable_mask);
    status_byte[srr_pkg::SB_QUEUE] = status_byte[srr_pkg::SB_QUES] | err_queue_nonempty;
    status_byte[srr_pkg::SB_MAV] = msg_avail;
    status_byte[srr_pkg::SB_ESB] = std_event_summary;
    status_byte[srr_pkg::SB_OPER] = |(op_event & op_enable);
    rqs = |(status_byte & sr_enable & ~(8'h01 << srr_pkg::SB_RQS));
    status_byte[srr_pkg::SB_RQS] = rqs;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      srq <= 1'h0;
    end else if (clk_en) begin
      srq <= rqs;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_data <= srr_pkg::GROUP_RESET;
      rd_valid <= 1'h0;
    end else if (clk_en) begin
      rd_valid <= rd_stb;
      if (rd_stb) begin
        case (reg_sel)
          srr_pkg::SEL_OP_COND: begin
            rd_data <= op_cond & ~srr_pkg::OP_COND_ZERO;
          end
          srr_pkg::SEL_OP_EVENT: begin
            rd_data <= op_event;
          end
          srr_pkg::SEL_OP_ENABLE: begin
            rd_data <= op_enable;
          end
          srr_pkg::SEL_QUES_COND: begin
            rd_data <= ques_cond & ~srr_pkg::Q_UNUSED;
          end
          srr_pkg::SEL_QUES_EVENT: begin
            rd_data <= ques_event;
          end
          srr_pkg::SEL_QUES_ENABLE: begin
            rd_data <= questionable_enable_mask;
          end
          srr_pkg::SEL_STATUS_BYTE: begin
            rd_data <= {8'h00, status_byte};
          end
          default: begin
            rd_data <= {8'h00, sr_enable};
          end
        endcase
      end
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_ques_edge_sets: assert property (
    clk_en && |(next_ques_cond & ~ques_cond)
    |=> (($past(next_ques_cond) & ~$past(ques_cond) & ~ques_event) == 16'h0000))
    else $error("rising questionable condition did not set event");

  a_op_read_clear: assert property (
    clk_en && op_rd_clr
    |=> ((op_event & ~($past(next_op_cond) & ~$past(op_cond))) == 16'h0000)
        && rd_data == $past(op_event))
    else $error("operation event read did not return and clear");

  a_ques_event_sticky: assert property (
    clk_en && !q_rd_clr |=> (($past(ques_event) & ~ques_event) == 16'h0000))
    else $error("questionable event bit dropped without a read");

  a_clear_keeps_edge: assert property (
    clk_en && q_rd_clr && next_ques_cond[srr_pkg::Q_THERMAL] && !ques_cond[srr_pkg::Q_THERMAL]
    |=> ques_event[srr_pkg::Q_THERMAL])
    else $error("edge lost during clearing read");

  a_op_cond_zero: assert property (
    clk_en && rd_stb && reg_sel == srr_pkg::SEL_OP_COND
    |=> rd_valid && (rd_data & srr_pkg::OP_COND_ZERO) == 16'h0000)
    else $error("unused or hidden operation bit read nonzero");

  a_ques_unused: assert property (
    (ques_cond & srr_pkg::Q_UNUSED) == 16'h0000 && (ques_event & srr_pkg::Q_UNUSED) == 16'h0000)
    else $error("unused questionable bit set");

  a_ques_summary: assert property (
    clk_en && sr_enable[srr_pkg::SB_QUES] && |(ques_event & questionable_enable_mask) |=> srq)
    else $error("enabled questionable event missed status bit 3");

  a_srq_follows: assert property (
    clk_en && (sr_enable[srr_pkg::SB_MAV] && msg_avail) |=> srq)
    else $error("service request line not raised");

  a_srq_quiet: assert property (
    clk_en && (status_byte & sr_enable & 8'hBF) == 8'h00 |=> !srq)
    else $error("service request raised with no enabled bit");

  a_wait_hold: assert property (
    clk_en && trig_ext_src && trigger_wait_flag && !trig_sync |=> trigger_wait_flag)
    else $error("trigger wait bit dropped while input low");

  a_prot_both: assert property (
    clk_en && ext_ref_en && (volt_prot_err || curr_prot_err)
    |=> ques_cond[srr_pkg::Q_VPROT] && ques_cond[srr_pkg::Q_CPROT])
    else $error("protection error did not set both bits");

endmodule

// File: common/srr_pkg.sv
package srr_pkg;
  localparam int GROUP_W = 16;
  localparam int BYTE_W = 8;
  // register selects on the command port
  localparam logic [2:0] SEL_OP_COND = 3'h0;
  localparam logic [2:0] SEL_OP_EVENT = 3'h1;
  localparam logic [2:0] SEL_OP_ENABLE = 3'h2;
  localparam logic [2:0] SEL_QUES_COND = 3'h3;
  localparam logic [2:0] SEL_QUES_EVENT = 3'h4;
  localparam logic [2:0] SEL_QUES_ENABLE = 3'h5;
  localparam logic [2:0] SEL_STATUS_BYTE = 3'h6;
  localparam logic [2:0] SEL_SR_ENABLE = 3'h7;
  // reset values
  localparam logic [15:0] GROUP_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // operation bit positions
  localparam int OP_WAIT_TRIG = 5;
  localparam int OP_ARMED = 6;
  localparam int OP_CV = 8;
  localparam int OP_TRANS_DONE = 9;
  localparam int OP_CC = 10;
  localparam int OP_SAMPLE_DONE = 11;
  localparam int OP_LIST_DONE = 12;
  localparam int OP_LIST_RUN = 14;
  // bits that read zero in the operation condition register
  localparam logic [15:0] OP_COND_ZERO = 16'hB29F;
  // questionable bit positions
  localparam int Q_CURR_MODE = 0;
  localparam int Q_VOLT_MODE = 1;
  localparam int Q_THERMAL = 3;
  localparam int Q_SLAVE = 6;
  localparam int Q_VPROT = 12;
  localparam int Q_CPROT = 13;
  localparam int Q_SINK = 14;
  localparam logic [15:0] Q_UNUSED = 16'h8FB4;
  // status byte bit positions
  localparam int SB_QUEUE = 3;
  localparam int SB_QUES = 3;
  localparam int SB_MAV = 4;
  localparam int SB_ESB = 5;
  localparam int SB_RQS = 6;
  localparam int SB_OPER = 7;
endpackage

// File: test/srr_host_model.sv
`timescale 1ns/1ns
module srr_host_model (
  input wire logic ref_clk,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  output logic [2:0] reg_sel,
  output logic rd_stb,
  output logic wr_stb,
  output logic [15:0] wr_data
);
  initial begin
    reg_sel = 3'h0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    wr_data = 16'h0000;
  end
  // one-cycle write strobe; data scrambled once released
  task automatic wr(input logic [2:0] sel, input logic [15:0] d);
    @(posedge ref_clk);
    reg_sel <= sel;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    wr_data <= ~d;
  endtask
  // answer lands on the same edge that takes the strobe
  task automatic rd(input logic [2:0] sel, output logic [15:0] d, output logic v);
    @(posedge ref_clk);
    reg_sel <= sel;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    d = rd_data;
    v = rd_valid;
  endtask
endmodule

// File: test/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] op_in = 16'h0000;
  logic [15:0] q_in = 16'h0000;
  logic [7:0] sb_in = 8'h00;
  logic [2:0] reg_sel;
  logic rd_stb, wr_stb, rd_valid, srq;
  logic [15:0] wr_data, rd_data, dd;
  logic vv;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #2 ref_clk = ~ref_clk;
  srr_host_model i_srr_host_model (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .reg_sel(reg_sel), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data));
  srr_status_regs i_srr_status_regs (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .reg_sel(reg_sel), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .srq(srq),
    .trig_enabled(op_in[5]), .trig_ext_src(op_in[0]), .trig_in(op_in[1]),
    .transient_armed(op_in[6]), .cv_mode(op_in[8]), .cc_mode(op_in[10]),
    .transient_done(op_in[9]), .sample_done(op_in[11]), .list_done(op_in[12]),
    .list_running(op_in[14]), .current_mode(q_in[0]), .voltage_mode(q_in[1]),
    .thermal_err(q_in[3]), .slave_fault(q_in[6]), .volt_prot_err(q_in[12]),
    .curr_prot_err(q_in[13]), .ext_ref_en(q_in[2]), .sinking(q_in[14]),
    .std_event_summary(sb_in[5]), .err_queue_nonempty(sb_in[3]), .msg_avail(sb_in[4]));
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [2:0] sel, input logic [15:0] exp);
    i_srr_host_model.rd(sel, dd, vv);
    chk({vv, dd}, {1'b1, exp});
  endtask
  task automatic setq(input logic [15:0] v);
    @(posedge ref_clk);
    q_in <= v;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rdc(srr_pkg::SEL_OP_COND, 16'h0000);
    rdc(srr_pkg::SEL_STATUS_BYTE, 16'h0000);
    setq(16'h0008);
    rdc(srr_pkg::SEL_QUES_COND, 16'h0008);
    rdc(srr_pkg::SEL_STATUS_BYTE, 16'h0000);
    rdc(srr_pkg::SEL_QUES_EVENT, 16'h0008);
    rdc(srr_pkg::SEL_QUES_EVENT, 16'h0000);
    i_srr_host_model.wr(srr_pkg::SEL_QUES_ENABLE, 16'hFFFF);
    rdc(srr_pkg::SEL_QUES_ENABLE, 16'hFFFF);
    i_srr_host_model.wr(srr_pkg::SEL_SR_ENABLE, 16'hFF08);
    rdc(srr_pkg::SEL_SR_ENABLE, 16'h0008);
    setq(16'h0048);
    rdc(srr_pkg::SEL_STATUS_BYTE, 16'h0048);
    chk({16'h0000, srq}, 17'h00001);
    rdc(srr_pkg::SEL_QUES_EVENT, 16'h0040);
    rdc(srr_pkg::SEL_STATUS_BYTE, 16'h0000);
    chk({16'h0000, srq}, 17'h00000);
    setq(16'hFFFB);
    rdc(srr_pkg::SEL_QUES_COND, 16'h704B);
    setq(16'h504B);
    rdc(srr_pkg::SEL_QUES_COND, 16'h504B);
    setq(16'h504F);
    rdc(srr_pkg::SEL_QUES_COND, 16'h704B);
    i_srr_host_model.wr(srr_pkg::SEL_QUES_COND, 16'h0000);
    rdc(srr_pkg::SEL_QUES_COND, 16'h704B);
    rdc(srr_pkg::SEL_QUES_EVENT, 16'h7003);
    setq(16'h0000);
    @(posedge ref_clk);
    op_in <= 16'hFFFF;
    rdc(srr_pkg::SEL_OP_COND, 16'h4D60);
    rdc(srr_pkg::SEL_OP_EVENT, 16'h5F60);
    @(posedge ref_clk);
    op_in <= 16'h0021;
    rdc(srr_pkg::SEL_OP_COND, 16'h0020);
    @(posedge ref_clk);
    op_in <= 16'h0001;
    rdc(srr_pkg::SEL_OP_COND, 16'h0020);
    @(posedge ref_clk);
    op_in <= 16'h0003;
    repeat (4) @(posedge ref_clk);
    rdc(srr_pkg::SEL_OP_COND, 16'h0000);
    i_srr_host_model.rd(srr_pkg::SEL_OP_EVENT, dd, vv);
    fork
      begin
        @(posedge ref_clk);
        op_in[11] <= 1'b1;
      end
      rdc(srr_pkg::SEL_OP_EVENT, 16'h0000);
    join
    rdc(srr_pkg::SEL_OP_EVENT, 16'h0800);
    @(posedge ref_clk);
    sb_in <= 8'h08;
    rdc(srr_pkg::SEL_STATUS_BYTE, 16'h0048);
    @(posedge ref_clk);
    sb_in <= 8'h10;
    rdc(srr_pkg::SEL_STATUS_BYTE, 16'h0010);
    i_srr_host_model.wr(srr_pkg::SEL_SR_ENABLE, 16'h0010);
    rdc(srr_pkg::SEL_STATUS_BYTE, 16'h0050);
    chk({16'h0000, srq}, 17'h00001);
    // frozen: strobe ignored, condition change waits for the enable
    @(posedge ref_clk);
    clk_en <= 1'b0;
    q_in <= 16'h0008;
    i_srr_host_model.rd(srr_pkg::SEL_QUES_COND, dd, vv);
    chk({vv, dd}, 17'h00050);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rdc(srr_pkg::SEL_QUES_EVENT, 16'h0008);
    // mid-run reset returns enables and the request line to zero
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rdc(srr_pkg::SEL_SR_ENABLE, 16'h0000);
    chk({16'h0000, srq}, 17'h00000);
    i_srr_host_model.wr(srr_pkg::SEL_OP_ENABLE, 16'h0800);
    rdc(srr_pkg::SEL_OP_ENABLE, 16'h0800);
    @(posedge ref_clk);
    sb_in <= 8'h30;
    rdc(srr_pkg::SEL_STATUS_BYTE, 16'h00B0);
    summarize();
  end
endmodule
